// [hw/tcs_pkg.sv]
package tcs_pkg;

  // register addresses on the special-function register bus
  localparam logic [7:0] TCS_ADDR_CLOCK_CONTROL = 8'h8E;
  localparam logic [7:0] TCS_ADDR_RUN_CONTROL = 8'h88;
  localparam logic [7:0] TCS_ADDR_MODE = 8'h89;
  localparam logic [7:0] TCS_ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] TCS_ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] TCS_ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] TCS_ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] TCS_ADDR_IRQ_ENABLE = 8'hA8;

  // reset values
  localparam logic [7:0] TCS_RST_BYTE = 8'h00;

  // clock control fields
  localparam int TCS_CK_T3_HIGH = 7;
  localparam int TCS_CK_T3_LOW = 6;
  localparam int TCS_CK_T2_HIGH = 5;
  localparam int TCS_CK_T2_LOW = 4;
  localparam int TCS_CK_T1_SYS = 3;
  localparam int TCS_CK_T0_SYS = 2;
  localparam int TCS_CK_PS_HI = 1;
  localparam int TCS_CK_PS_LO = 0;

  // run control fields
  localparam int TCS_RC_TF1 = 7;
  localparam int TCS_RC_TR1 = 6;
  localparam int TCS_RC_TF0 = 5;
  localparam int TCS_RC_TR0 = 4;

  // mode register fields
  localparam int TCS_MD_T1_CT = 6;
  localparam int TCS_MD_T1_HI = 5;
  localparam int TCS_MD_T1_LO = 4;
  localparam int TCS_MD_T0_CT = 2;
  localparam int TCS_MD_T0_HI = 1;
  localparam int TCS_MD_T0_LO = 0;

  // interrupt enable fields
  localparam int TCS_IE_ET1 = 3;
  localparam int TCS_IE_ET0 = 1;
  localparam logic [7:0] TCS_IE_MASK = 8'h0A;

  // low-byte width of the 13-bit mode
  localparam int TCS_M13_LOW_W = 5;

  // prescaler ratios
  localparam int TCS_DIV_SYS12 = 12;
  localparam int TCS_DIV_SYS4 = 4;
  localparam int TCS_DIV_EXT8 = 8;

  typedef enum logic [1:0] {
    TCS_MODE_13BIT = 2'b00,
    TCS_MODE_16BIT = 2'b01,
    TCS_MODE_8RELOAD = 2'b10,
    TCS_MODE_SPLIT = 2'b11
  } tcs_mode_t;

  typedef enum logic [1:0] {
    TCS_PS_SYS12 = 2'b00,
    TCS_PS_SYS4A = 2'b01,
    TCS_PS_SYS4B = 2'b10,
    TCS_PS_EXT8 = 2'b11
  } tcs_presc_t;

endpackage

// [hw/tcs_prescaler.sv]
`timescale 1ns/100ps
module tcs_prescaler
  import tcs_pkg::*;
(
  input logic clock, // system clock
  input logic rstn, // async reset, active low
  input logic ext_osc_clk, // external oscillator, asynchronous
  output logic tick_sys12, // one-cycle tick, system clock / 12
  output logic tick_sys4, // one-cycle tick, system clock / 4
  output logic tick_ext8 // one-cycle tick, external clock / 8
);

  localparam logic [3:0] LAST12 = 4'(TCS_DIV_SYS12 - 1);
  localparam logic [1:0] LAST4 = 2'(TCS_DIV_SYS4 - 1);
  localparam logic [2:0] LAST8 = 3'(TCS_DIV_EXT8 - 1);

  logic [3:0] c12_q;
  logic [1:0] c4_q;
  logic [2:0] c8_q;
  logic sync1_q, sync2_q, ext_prev_q;
  logic ext_rise;

  // free-running system dividers; ticks are enables, never clocks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      c12_q <= 4'h0;
      c4_q <= 2'h0;
    end else begin
      c12_q <= (c12_q == LAST12) ? 4'h0 : c12_q + 4'h1;
      c4_q <= c4_q + 2'h1;
    end
  end

  // two-flop synchroniser for the external clock, then edge detect on stage two only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      sync1_q <= ext_osc_clk;
      sync2_q <= sync1_q;
      ext_prev_q <= sync2_q;
    end
  end

  assign ext_rise = sync2_q & ~ext_prev_q;

  // count external rising edges; limited to well under half the system rate
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      c8_q <= 3'h0;
    end else if (ext_rise) begin
      c8_q <= c8_q + 3'h1;
    end
  end

  assign tick_sys12 = (c12_q == LAST12);
  assign tick_sys4 = (c4_q == LAST4);
  assign tick_ext8 = ext_rise & (c8_q == LAST8);

  a_div12_period: assert property (@(posedge clock) disable iff (!rstn)
    tick_sys12 |=> !tick_sys12 [*8] ##1 !tick_sys12 [*3] ##1 tick_sys12)
    else $error("div12 tick period wrong");

  a_div4_period: assert property (@(posedge clock) disable iff (!rstn)
    tick_sys4 |=> !tick_sys4 [*3] ##1 tick_sys4) else $error("div4 tick period wrong");

endmodule // tcs_prescaler

// [hw/tcs_timer_clock_select.sv]
`timescale 1ns/100ps
// Operation
// - t3 high byte split: ext select or sysclk
// - t3 or low byte: ext select or sysclk
// - t2 high byte split: ext select or sysclk
// - t2 or low byte: ext select or sysclk
// - timer 1: prescaled tick or sysclk
// - timer 0: prescaled tick or sysclk
// - counter mode overrides the clock select bit, except timer 1 and the timer 0 high byte while timer 0 split
// - prescale code picks div12, div4 or ext/8
// - each timer sixteen bits, two byte registers
// - run control holds enables and overflow flags
// - overflow interrupt only while its enable set
// - four modes per timer from mode bits
// - timer settings apart from the shared prescale code are independent except while timer 0 is split
// - counter mode counts input falling edges
// - t2/t3 ext select: sys/12 or ext/8
module tcs_timer_clock_select
  import tcs_pkg::*;
(
  input logic clock, // system clock, 125 MHz
  input logic rstn, // async reset, active low
  input logic [7:0] sfr_addr, // register address
  input logic sfr_wr, // write strobe
  input logic [7:0] sfr_wdata, // write data
  input logic sfr_rd, // read strobe
  output logic [7:0] sfr_rdata, // read data, valid the cycle after sfr_rd
  input logic ext_osc_clk, // external oscillator clock
  input logic tmr0_count_input, // timer 0 event pin
  input logic tmr1_count_input, // timer 1 event pin
  input logic tmr2_ext_clock_sel, // timer 2 external clock selection
  input logic tmr2_split, // timer 2 in split 8-bit mode
  input logic tmr3_ext_clock_sel, // timer 3 external clock selection
  input logic tmr3_split, // timer 3 in split 8-bit mode
  output logic tmr2_low_tick, // timer 2 (low byte) count enable
  output logic tmr2_high_tick, // timer 2 high byte count enable
  output logic tmr3_low_tick, // timer 3 (low byte) count enable
  output logic tmr3_high_tick, // timer 3 high byte count enable
  output logic tmr0_irq, // timer 0 interrupt request
  output logic tmr1_irq, // timer 1 interrupt request
  output logic tmr1_overflow // timer 1 overflow pulse, for baud rates
);

  // step one timer by one count; returns {overflow, high, low}
  function automatic logic [16:0] tcs_step(input tcs_mode_t m, input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [12:0] c13;
    logic [7:0] l;
    logic [7:0] h;
    logic o;
    c13 = {hi, lo[TCS_M13_LOW_W-1:0]} + 13'h0001;
    l = lo;
    h = hi;
    o = 1'b0;
    case (m)
      TCS_MODE_13BIT: begin
        o = &{hi, lo[TCS_M13_LOW_W-1:0]};
        h = c13[12:TCS_M13_LOW_W];
        l[TCS_M13_LOW_W-1:0] = c13[TCS_M13_LOW_W-1:0];
      end
      TCS_MODE_16BIT: begin
        o = &{hi, lo};
        {h, l} = {hi, lo} + 16'h0001;
      end
      TCS_MODE_8RELOAD: begin
        o = &lo;
        l = o ? hi : lo + 8'h01;
      end
      default: begin
        o = &lo;
        l = lo + 8'h01;
      end
    endcase
    return {o, h, l};
  endfunction

  logic [7:0] timer_clock_control_q, timer_run_control_q, timer_mode_register_q, ie_q, rdata_q;
  logic [7:0] tl0_q, th0_q, tl1_q, th1_q;
  logic [7:0] tl0_d, th0_d, tl1_d, th1_d;
  logic pin0_q, pin1_q;
  logic tick_sys12, tick_sys4, tick_ext8, presc_tick;
  logic t0_timer_tick, t1_timer_tick, t0_tick, t1_tick, fall0, fall1;
  logic t0_split, t1_run, ovf0, ovf0h, ovf1;
  logic [16:0] s0, s1;
  logic t2_ext_tick, t3_ext_tick;
  tcs_mode_t m0, m1;
  tcs_presc_t pcode;

  logic wr_ck, wr_tc, wr_md, wr_ie, wr_tl0, wr_th0, wr_tl1, wr_th1;
  assign wr_ck = sfr_wr && sfr_addr == TCS_ADDR_CLOCK_CONTROL;
  assign wr_tc = sfr_wr && sfr_addr == TCS_ADDR_RUN_CONTROL;
  assign wr_md = sfr_wr && sfr_addr == TCS_ADDR_MODE;
  assign wr_ie = sfr_wr && sfr_addr == TCS_ADDR_IRQ_ENABLE;
  assign wr_tl0 = sfr_wr && sfr_addr == TCS_ADDR_T0_LOW;
  assign wr_th0 = sfr_wr && sfr_addr == TCS_ADDR_T0_HIGH;
  assign wr_tl1 = sfr_wr && sfr_addr == TCS_ADDR_T1_LOW;
  assign wr_th1 = sfr_wr && sfr_addr == TCS_ADDR_T1_HIGH;

  tcs_prescaler u_presc (
    .clock(clock),
    .rstn(rstn),
    .ext_osc_clk(ext_osc_clk),
    .tick_sys12(tick_sys12),
    .tick_sys4(tick_sys4),
    .tick_ext8(tick_ext8)
  );

  assign pcode = tcs_presc_t'(timer_clock_control_q[TCS_CK_PS_HI:TCS_CK_PS_LO]);
  always_comb begin
    case (pcode)
      TCS_PS_SYS12: presc_tick = tick_sys12;
      TCS_PS_SYS4A, TCS_PS_SYS4B: presc_tick = tick_sys4;
      TCS_PS_EXT8: presc_tick = tick_ext8;
      default: presc_tick = 1'b0;
    endcase
  end

  // pins are synchronous; one stage of history gives the edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin0_q <= 1'b1;
      pin1_q <= 1'b1;
    end else begin
      pin0_q <= tmr0_count_input;
      pin1_q <= tmr1_count_input;
    end
  end

  // falling edge detect on the event pins
  assign fall0 = pin0_q & ~tmr0_count_input;
  assign fall1 = pin1_q & ~tmr1_count_input;

  assign t0_timer_tick = timer_clock_control_q[TCS_CK_T0_SYS] ? 1'b1 : presc_tick;
  assign t1_timer_tick = timer_clock_control_q[TCS_CK_T1_SYS] ? 1'b1 : presc_tick;
  // counter mode ignores the select bit
  assign t0_tick = timer_mode_register_q[TCS_MD_T0_CT] ? fall0 : t0_timer_tick;
  // timer 1 cannot count pin events while timer 0 is split
  assign t1_tick = (timer_mode_register_q[TCS_MD_T1_CT] && !t0_split) ? fall1 : t1_timer_tick;

  // per-timer mode fields, kept apart for independence
  assign m0 = tcs_mode_t'(timer_mode_register_q[TCS_MD_T0_HI:TCS_MD_T0_LO]);
  assign m1 = tcs_mode_t'(timer_mode_register_q[TCS_MD_T1_HI:TCS_MD_T1_LO]);
  assign t0_split = (m0 == TCS_MODE_SPLIT);
  // split timer 0 borrows the timer 1 enable, so timer 1 runs from its mode alone
  assign t1_run = t0_split ? (m1 != TCS_MODE_SPLIT) : (timer_run_control_q[TCS_RC_TR1] && m1 != TCS_MODE_SPLIT);

  assign s0 = tcs_step(m0, th0_q, tl0_q);
  assign s1 = tcs_step(m1, th1_q, tl1_q);

  // next values of the two 16-bit counts
  always_comb begin
    tl0_d = tl0_q;
    th0_d = th0_q;
    tl1_d = tl1_q;
    th1_d = th1_q;
    ovf0 = 1'b0;
    ovf0h = 1'b0;
    ovf1 = 1'b0;
    if (timer_run_control_q[TCS_RC_TR0] && t0_tick) begin
      {ovf0, th0_d, tl0_d} = s0;
      if (t0_split) begin
        th0_d = th0_q;
      end
    end
    // split high byte is a timer only, enabled by the timer 1 run bit
    if (t0_split && timer_run_control_q[TCS_RC_TR1] && t0_timer_tick) begin
      th0_d = th0_q + 8'h01;
      ovf0h = &th0_q;
    end
    if (t1_run && t1_tick) begin
      {ovf1, th1_d, tl1_d} = s1;
    end
  end

  // counts: a software write wins over the count in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tl0_q <= TCS_RST_BYTE;
      th0_q <= TCS_RST_BYTE;
      tl1_q <= TCS_RST_BYTE;
      th1_q <= TCS_RST_BYTE;
    end else begin
      tl0_q <= wr_tl0 ? sfr_wdata : tl0_d;
      th0_q <= wr_th0 ? sfr_wdata : th0_d;
      tl1_q <= wr_tl1 ? sfr_wdata : tl1_d;
      th1_q <= wr_th1 ? sfr_wdata : th1_d;
    end
  end

  // clock selects and prescale code clear on reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_clock_control_q <= TCS_RST_BYTE;
      timer_mode_register_q <= TCS_RST_BYTE;
      ie_q <= TCS_RST_BYTE;
    end else begin
      if (wr_ck) timer_clock_control_q <= sfr_wdata;
      if (wr_md) timer_mode_register_q <= sfr_wdata;
      if (wr_ie) ie_q <= sfr_wdata & TCS_IE_MASK;
    end
  end

  // run control; an overflow in the write cycle still sets its flag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_run_control_q <= TCS_RST_BYTE;
    end else begin
      if (wr_tc) timer_run_control_q <= sfr_wdata;
      if (ovf0) timer_run_control_q[TCS_RC_TF0] <= 1'b1;
      if (ovf0h || (ovf1 && !t0_split)) timer_run_control_q[TCS_RC_TF1] <= 1'b1;
    end
  end

  // read port, registered; unmapped addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= TCS_RST_BYTE;
    end else if (sfr_rd) begin
      case (sfr_addr)
        TCS_ADDR_CLOCK_CONTROL: rdata_q <= timer_clock_control_q;
        TCS_ADDR_RUN_CONTROL: rdata_q <= timer_run_control_q;
        TCS_ADDR_MODE: rdata_q <= timer_mode_register_q;
        TCS_ADDR_IRQ_ENABLE: rdata_q <= ie_q;
        TCS_ADDR_T0_LOW: rdata_q <= tl0_q;
        TCS_ADDR_T0_HIGH: rdata_q <= th0_q;
        TCS_ADDR_T1_LOW: rdata_q <= tl1_q;
        TCS_ADDR_T1_HIGH: rdata_q <= th1_q;
        default: rdata_q <= TCS_RST_BYTE;
      endcase
    end
  end
  assign sfr_rdata = rdata_q;

  // interrupt gating by the enable bits
  assign tmr0_irq = timer_run_control_q[TCS_RC_TF0] & ie_q[TCS_IE_ET0];
  assign tmr1_irq = timer_run_control_q[TCS_RC_TF1] & ie_q[TCS_IE_ET1];
  assign tmr1_overflow = ovf1;

  assign t2_ext_tick = tmr2_ext_clock_sel ? tick_ext8 : tick_sys12;
  assign t3_ext_tick = tmr3_ext_clock_sel ? tick_ext8 : tick_sys12;
  assign tmr2_low_tick = timer_clock_control_q[TCS_CK_T2_LOW] ? 1'b1 : t2_ext_tick;
  // timer 2 high byte, own select only when split
  assign tmr2_high_tick = !tmr2_split ? tmr2_low_tick :
                          (timer_clock_control_q[TCS_CK_T2_HIGH] ? 1'b1 : t2_ext_tick);
  assign tmr3_low_tick = timer_clock_control_q[TCS_CK_T3_LOW] ? 1'b1 : t3_ext_tick;
  // timer 3 high byte, own select only when split
  assign tmr3_high_tick = !tmr3_split ? tmr3_low_tick :
                          (timer_clock_control_q[TCS_CK_T3_HIGH] ? 1'b1 : t3_ext_tick);

  a_t0_sysclk_count: assert property (@(posedge clock) disable iff (!rstn)
    (timer_run_control_q[TCS_RC_TR0] && timer_clock_control_q[TCS_CK_T0_SYS] && !timer_mode_register_q[TCS_MD_T0_CT] &&
     m0 == TCS_MODE_16BIT && !wr_tl0 && !wr_th0)
    |=> {th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001) else $error("t0 sysclk count");
  a_t1_presc_hold: assert property (@(posedge clock) disable iff (!rstn)
    (!timer_clock_control_q[TCS_CK_T1_SYS] && !timer_mode_register_q[TCS_MD_T1_CT] && pcode == TCS_PS_SYS12 &&
     !tick_sys12 && !wr_tl1 && !wr_th1) |=> $stable({th1_q, tl1_q})) else $error("t1 prescale hold");
  a_ct_ignores_sel: assert property (@(posedge clock) disable iff (!rstn)
    (timer_mode_register_q[TCS_MD_T0_CT] && timer_clock_control_q[TCS_CK_T0_SYS] && !fall0 && !t0_split && !wr_tl0 &&
     !wr_th0) |=> $stable({th0_q, tl0_q})) else $error("counter mode used clock select");
  a_fall_counts: assert property (@(posedge clock) disable iff (!rstn)
    (timer_mode_register_q[TCS_MD_T0_CT] && fall0 && timer_run_control_q[TCS_RC_TR0] && m0 == TCS_MODE_16BIT &&
     !wr_tl0 && !wr_th0) |=> tl0_q == $past(tl0_q) + 8'h01) else $error("falling edge missed");
  a_tf0_set_wins: assert property (@(posedge clock) disable iff (!rstn)
    ovf0 |=> timer_run_control_q[TCS_RC_TF0]) else $error("overflow flag lost");
  a_irq_masked: assert property (@(posedge clock) disable iff (!rstn)
    (!ie_q[TCS_IE_ET0] && ovf0 && !wr_ie) |=> !tmr0_irq) else $error("masked irq raised");
  a_t3_low_sys: assert property (@(posedge clock) disable iff (!rstn)
    $rose(timer_clock_control_q[TCS_CK_T3_LOW]) |-> tmr3_low_tick [*2]) else $error("t3 low not sysclk");
  a_t2_high_div12: assert property (@(posedge clock) disable iff (!rstn)
    (tmr2_split && !timer_clock_control_q[TCS_CK_T2_HIGH] && !tmr2_ext_clock_sel) |->
    tmr2_high_tick == tick_sys12) else $error("t2 high wrong source");
  a_t1_indep: assert property (@(posedge clock) disable iff (!rstn)
    (wr_md && sfr_wdata[TCS_MD_T1_HI:TCS_MD_T1_LO] == timer_mode_register_q[TCS_MD_T1_HI:TCS_MD_T1_LO])
    |=> m1 == $past(m1)) else $error("t1 mode disturbed");

endmodule // tcs_timer_clock_select

// [testbench/tcs_tb.sv]
`timescale 1ns/100ps
// the external oscillator is held still until t_ext, so every ext/8 path must stay quiet before it
module testbench
  import tcs_pkg::*;
;
  logic clock, rstn, sfr_wr, sfr_rd, ext_osc_clk, pin0, pin1, ovf1;
  logic t2_sel, t2_split, t3_sel, t3_split, t2l, t2h, t3l, t3h, irq0, irq1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  int fails, n_tests;
  int n_ovf = 0;

  tcs_timer_clock_select uut (
    .clock(clock), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .ext_osc_clk(ext_osc_clk), .tmr0_count_input(pin0), .tmr1_count_input(pin1),
    .tmr2_ext_clock_sel(t2_sel), .tmr2_split(t2_split), .tmr3_ext_clock_sel(t3_sel),
    .tmr3_split(t3_split), .tmr2_low_tick(t2l), .tmr2_high_tick(t2h),
    .tmr3_low_tick(t3l), .tmr3_high_tick(t3h), .tmr0_irq(irq0), .tmr1_irq(irq1),
    .tmr1_overflow(ovf1)
  );

  // system clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // overflow pulses last one cycle, so count them on the sampling edge
  always @(posedge clock) n_ovf <= n_ovf + int'(ovf1);

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask

  // read data holds until the next read, so a late sample is safe
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    @(negedge clock);
    check({8'h00, sfr_rdata}, exp);
  endtask

  task automatic pre(input logic [7:0] l0, h0, l1, h1);
    wr(TCS_ADDR_T0_LOW, l0);
    wr(TCS_ADDR_T0_HIGH, h0);
    wr(TCS_ADDR_T1_LOW, l1);
    wr(TCS_ADDR_T1_HIGH, h1);
  endtask

  task automatic chk4(input int l0, h0, l1, h1);
    rdc(TCS_ADDR_T0_LOW, 16'(l0)); // low byte
    rdc(TCS_ADDR_T0_HIGH, 16'(h0)); // high byte
    rdc(TCS_ADDR_T1_LOW, 16'(l1)); // low byte
    rdc(TCS_ADDR_T1_HIGH, 16'(h1)); // high byte
  endtask

  // run window is exactly 120 count edges, a multiple of both divide ratios
  task automatic run(input logic [7:0] tc, input logic [7:0] flags, input logic [1:0] irqs);
    wr(TCS_ADDR_RUN_CONTROL, tc);
    repeat (115) @(negedge clock);
    rdc(TCS_ADDR_RUN_CONTROL, 16'(tc | flags)); // run and flag bits
    check({14'h0000, irq1, irq0}, {14'h0000, irqs}); // gated requests
    wr(TCS_ADDR_RUN_CONTROL, 8'h00);
    check({14'h0000, irq1, irq0}, 16'h0000); // cleared flags
  endtask

  task automatic t_reset();
    logic [7:0] a [8] = '{TCS_ADDR_CLOCK_CONTROL, TCS_ADDR_RUN_CONTROL, TCS_ADDR_MODE,
      TCS_ADDR_T0_LOW, TCS_ADDR_T1_LOW, TCS_ADDR_T0_HIGH, TCS_ADDR_T1_HIGH, TCS_ADDR_IRQ_ENABLE};
    foreach (a[i]) rdc(a[i], 16'h0000); // reset values
    rdc(8'h90, 16'h0000); // unmapped reads zero
    wr(TCS_ADDR_IRQ_ENABLE, 8'hFF);
    rdc(TCS_ADDR_IRQ_ENABLE, 16'h000A); // only enables stored
    wr(TCS_ADDR_CLOCK_CONTROL, 8'hA5);
    rdc(TCS_ADDR_CLOCK_CONTROL, 16'h00A5); // read back
    wr(TCS_ADDR_IRQ_ENABLE, 8'h00);
    $display("reset test done");
  endtask

  task automatic tk(input logic [7:0] ck, input logic sp, xs, input int e2l, e2h, e3l, e3h);
    int c [4] = '{0, 0, 0, 0};
    wr(TCS_ADDR_CLOCK_CONTROL, ck);
    t2_split = sp;
    t3_split = sp;
    t2_sel = xs;
    t3_sel = xs;
    repeat (48) begin
      @(negedge clock);
      c[0] += int'(t2l);
      c[1] += int'(t2h);
      c[2] += int'(t3l);
      c[3] += int'(t3h);
    end
    check(16'(c[0]), 16'(e2l)); // timer 2 low
    check(16'(c[1]), 16'(e2h)); // timer 2 high
    check(16'(c[2]), 16'(e3l)); // timer 3 low
    check(16'(c[3]), 16'(e3h)); // timer 3 high
  endtask

  task automatic t_ticks();
    tk(8'h00, 1'b1, 1'b0, 4, 4, 4, 4); // sys/12 path
    tk(8'hF0, 1'b1, 1'b0, 48, 48, 48, 48); // all sysclk
    tk(8'h50, 1'b1, 1'b0, 48, 4, 48, 4); // low bytes only
    tk(8'hA0, 1'b1, 1'b0, 4, 48, 4, 48); // high bytes only
    tk(8'hA0, 1'b0, 1'b0, 4, 4, 4, 4); // high select needs split
    tk(8'h00, 1'b1, 1'b1, 0, 0, 0, 0); // ext/8 path, oscillator still
    $display("tick select test done");
  endtask

  task automatic t_prescale();
    int e [4] = '{120 / TCS_DIV_SYS12, 120 / TCS_DIV_SYS4, 120 / TCS_DIV_SYS4, 0};
    wr(TCS_ADDR_MODE, 8'h11);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        wr(TCS_ADDR_CLOCK_CONTROL, ((s == 0) ? 8'h08 : 8'h04) | 8'(k));
        pre(8'h00, 8'h00, 8'h00, 8'h00);
        run(8'h50, 8'h00, 2'b00);
        chk4((s == 0) ? e[k] : 120, 0, (s == 0) ? 120 : e[k], 0);
      end
    end
    $display("prescaler test done");
  endtask

  task automatic t_wide();
    wr(TCS_ADDR_MODE, 8'h11);
    wr(TCS_ADDR_CLOCK_CONTROL, 8'h0C);
    wr(TCS_ADDR_IRQ_ENABLE, 8'h08);
    pre(8'hFE, 8'h12, 8'hFF, 8'hFF);
    run(8'h50, 8'h80, 2'b10); // timer 1 wraps
    chk4(8'h76, 8'h13, 8'h77, 8'h00); // carry into high byte
    $display("sixteen bit test done");
  endtask

  task automatic t_modes();
    int n0;
    wr(TCS_ADDR_MODE, 8'h20);
    wr(TCS_ADDR_IRQ_ENABLE, 8'h00);
    pre(8'h00, 8'h00, 8'hF0, 8'hF0);
    n0 = n_ovf;
    run(8'h50, 8'h80, 2'b00); // masked request
    chk4(8'h18, 8'h03, 8'hF8, 8'hF0); // thirteen bit and reload
    check(16'(n_ovf - n0), 16'd7); // reload period
    $display("mode test done");
  endtask

  // pin 0 is held low three cycles and high four, pin 1 only on the first three pulses, well inside the sampling limit
  task automatic t_counter();
    wr(TCS_ADDR_MODE, 8'h55);
    wr(TCS_ADDR_CLOCK_CONTROL, 8'h0C);
    pre(8'h00, 8'h00, 8'h00, 8'h00);
    wr(TCS_ADDR_RUN_CONTROL, 8'h50);
    for (int i = 0; i < 5; i++) begin
      @(negedge clock);
      pin0 = 1'b0;
      pin1 = (i >= 3);
      repeat (3) @(negedge clock);
      pin0 = 1'b1;
      pin1 = 1'b1;
      repeat (3) @(negedge clock);
    end
    wr(TCS_ADDR_RUN_CONTROL, 8'h00);
    chk4(5, 0, 3, 0); // falling edges only
    $display("counter test done");
  endtask

  // timer 0 split: high byte runs on the timer 1 enable and sets its flag
  task automatic t_split();
    wr(TCS_ADDR_MODE, 8'h33);
    wr(TCS_ADDR_CLOCK_CONTROL, 8'h0C);
    wr(TCS_ADDR_IRQ_ENABLE, 8'h08);
    pre(8'h00, 8'hF0, 8'h00, 8'h00);
    run(8'h50, 8'h80, 2'b10); // split high byte sets timer 1 flag
    chk4(8'h78, 8'h68, 0, 0); // two bytes apart, timer 1 stopped
    $display("split mode test done");
  endtask

  // oscillator at one eighth of the system rate gives one tick per 64 cycles
  task automatic t_ext();
    int c [2] = '{0, 0};
    wr(TCS_ADDR_MODE, 8'h11);
    wr(TCS_ADDR_CLOCK_CONTROL, 8'h03);
    wr(TCS_ADDR_IRQ_ENABLE, 8'h02);
    pre(8'hFE, 8'hFF, 8'h00, 8'h00);
    t2_split = 1'b0;
    t3_split = 1'b0;
    t2_sel = 1'b1;
    t3_sel = 1'b1;
    wr(TCS_ADDR_RUN_CONTROL, 8'h10);
    for (int i = 0; i < 300; i++) begin
      @(negedge clock);
      if (i % 4 == 0) ext_osc_clk = ~ext_osc_clk;
      c[0] += int'(t2l);
      c[1] += int'(t3l);
    end
    check(16'(c[0]), 16'd4); // timer 2 ext/8
    check(16'(c[1]), 16'd4); // timer 3 ext/8
    rdc(TCS_ADDR_RUN_CONTROL, 16'h0030); // overflow flag set
    check({15'h0000, irq0}, 16'h0001); // enabled request
    wr(TCS_ADDR_RUN_CONTROL, 8'h00);
    ext_osc_clk = 1'b0;
    chk4(2, 0, 0, 0); // ext/8 prescale wraps timer 0
    $display("external clock test done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    ext_osc_clk = 1'b0;
    pin0 = 1'b1;
    pin1 = 1'b1;
    t2_sel = 1'b0;
    t3_sel = 1'b0;
    t2_split = 1'b0;
    t3_split = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    t_reset();
    t_ticks();
    t_prescale();
    t_wide();
    t_modes();
    t_counter();
    t_split();
    t_ext();
    wrap_up();
  end

  // watchdog, far beyond the length of the whole sequence
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    wrap_up();
  end
endmodule // testbench
